/* hbp_host_port.sv */
// Host bus port: strobe decoding, acknowledge timing, interrupt context capture.
// Assumes pins arrive asynchronously; arbitration and FIFOs sit outside on i_clock.
//
// Overview of operation
// - Pin high or open selects separate strobes; low selects acknowledge style.
// - Separate strobes: write latched on first rise of select or write strobe.
// - Separate strobes: read data driven while select and read strobe both low.
// - Acknowledge style: write with select low, direction low, captured at acknowledge.
// - Acknowledge style: read driven while select low, direction high; acknowledge when valid.
// - Acknowledge style: write completes at first of select rise or acknowledge.
// - Seven-bit address decode and eight-bit bidirectional data bus.
// - Acknowledge is open-drain active low, delay chosen by config bits 7:6.
// - Delay counted in system clocks from select fall, at least two edges.
// - Select withdrawn before acknowledge abandons it; cycle ends with strobe timing.
// - Acknowledge released to high impedance at end of each cycle.
// - Interrupt acknowledge drives the vector, and in acknowledge style an acknowledge.
// - Interrupt acknowledge or refresh command captures latest arbitration winner.
// - Vector is fixed or vector register, optionally modified with type and channel.
// - Captured interrupt value holds until next acknowledge or refresh command.
// - Global byte count register redirects by captured context, to byte count of rx or tx.
// - Global FIFO window pops the rx FIFO on reads and pushes the tx FIFO on writes, whatever the captured context.
// - No interrupt above threshold captures zero and zeroes vector context bits.
// - System clock is the timing reference for all control logic.
`timescale 1ns/1ps
`include "hbp_defines.svh"
module hbp_host_port
  import hbp_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_bus_style_select,
  input wire logic i_chip_select_low,
  input wire logic i_read_strobe_low,
  input wire logic i_write_strobe_low,
  input wire logic i_read_write_select,
  input wire logic i_intr_ack_low,
  input wire logic [6:0] i_addr,
  input wire logic [7:0] i_data,
  output logic [7:0] o_data,
  output logic o_data_oe,
  output logic o_transfer_ack_low,
  output logic o_transfer_ack_oe,
  input wire logic [7:0] i_global_chip_config,
  input wire logic [7:0] i_intr_control,
  input wire logic [7:0] i_vector_reg,
  input wire logic i_refresh_capture_command,
  input wire logic i_arb_valid,
  input wire logic [2:0] i_arb_type,
  input wire logic [4:0] i_arb_channel,
  input wire logic [7:0] i_reg_rdata,
  input wire logic [8:0] i_rx_fill,
  input wire logic [8:0] i_tx_fill,
  input wire logic [7:0] i_rx_fifo_data,
  output logic [7:0] o_current_intr_capture,
  output logic [6:0] o_reg_addr,
  output logic [7:0] o_reg_wdata,
  output logic o_reg_write,
  output logic o_reg_read,
  output logic o_rx_fifo_pop,
  output logic o_tx_fifo_push
);
  localparam int ACK_MIN = `HBP_ACK_MIN_EDGES;
  localparam int ACK_MID = `HBP_ACK_MID_EDGES;
  localparam int ACK_MAX = `HBP_ACK_MAX_EDGES;

  // Two flops per asynchronous pin; only the second stage is read.
  logic [5:0] sync1_reg;
  logic [5:0] sync2_reg;
  logic [6:0] addr_s1_reg;
  logic [6:0] addr_reg;
  logic [7:0] wd_s1_reg;
  logic [7:0] wdata_reg;
  logic [7:0] wdata_hold_reg;
  logic [5:0] pins;
  logic style_sep;
  logic cs;
  logic rd;
  logic wr;
  logic rw;
  logic iack;
  logic cs_prev_reg;
  logic wr_prev_reg;
  logic iack_prev_reg;
  logic rd_prev_reg;
  hbp_state_type state_reg;
  logic [2:0] cnt_reg;
  logic [2:0] ack_target;
  logic is_global;
  logic [7:0] read_value;
  logic [7:0] vector_value;
  logic write_event;
  logic read_event;
  logic capture_event;

  assign pins = {i_bus_style_select, i_chip_select_low, i_read_strobe_low,
                 i_write_strobe_low, i_read_write_select, i_intr_ack_low};

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      sync1_reg <= 6'h3F;
      sync2_reg <= 6'h3F;
      addr_s1_reg <= 7'h00;
      addr_reg <= 7'h00;
      wd_s1_reg <= 8'h00;
      wdata_reg <= 8'h00;
    end else begin
      sync1_reg <= pins;
      sync2_reg <= sync1_reg;
      addr_s1_reg <= i_addr;
      addr_reg <= addr_s1_reg;
      wd_s1_reg <= i_data;
      wdata_reg <= wd_s1_reg;
    end
  end

  assign style_sep = sync2_reg[5];
  assign cs = ~sync2_reg[4];
  assign rd = ~sync2_reg[3];
  assign wr = ~sync2_reg[2];
  assign rw = sync2_reg[1];
  assign iack = ~sync2_reg[0];

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      cs_prev_reg <= 1'b0;
      wr_prev_reg <= 1'b0;
      rd_prev_reg <= 1'b0;
      iack_prev_reg <= 1'b0;
    end else begin
      cs_prev_reg <= cs;
      wr_prev_reg <= wr;
      rd_prev_reg <= rd;
      iack_prev_reg <= iack;
    end
  end

  // Data is kept from the last selected sample, since a host may drop it with the select.
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      wdata_hold_reg <= 8'h00;
    end else if (cs) begin
      wdata_hold_reg <= wdata_reg;
    end
  end

  // Codes 2 and 3 both give the longest delay.
  always_comb begin
    case (i_global_chip_config[`HBP_ACK_DLY_MSB:`HBP_ACK_DLY_LSB])
      2'b00: ack_target = 3'(ACK_MIN);
      2'b01: ack_target = 3'(ACK_MID);
      default: ack_target = 3'(ACK_MAX);
    endcase
  end

  // Acknowledge sequencer, acknowledge style only.
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      state_reg <= HBP_IDLE;
      cnt_reg <= 3'h0;
    end else begin
      case (state_reg)
        HBP_IDLE: begin
          cnt_reg <= 3'h0;
          if (!style_sep && (cs || iack)) begin
            state_reg <= HBP_WAIT;
            cnt_reg <= 3'h1;
          end
        end
        HBP_WAIT: begin
          if (!(cs || iack)) begin
            state_reg <= HBP_IDLE;
          end else if (cnt_reg >= ack_target - 3'h1) begin
            state_reg <= HBP_ACK;
          end else begin
            cnt_reg <= cnt_reg + 3'h1;
          end
        end
        HBP_ACK: begin
          state_reg <= HBP_DONE;
        end
        HBP_DONE: begin
          if (!(cs || iack)) begin
            state_reg <= HBP_IDLE;
          end
        end
        default: state_reg <= HBP_IDLE;
      endcase
    end
  end

  // Open-drain: enable only while pulling low, released between cycles.
  assign o_transfer_ack_low = 1'b0;
  assign o_transfer_ack_oe = (state_reg == HBP_ACK) || (state_reg == HBP_DONE);

  // Write completion: first rise of select or write strobe, or the acknowledge.
  always_comb begin
    if (style_sep) begin
      write_event = (cs_prev_reg && wr_prev_reg) && !(cs && wr);
    end else begin
      write_event = (cs_prev_reg && !rw && !iack_prev_reg) &&
                    ((state_reg == HBP_ACK) ||
                     (!cs && state_reg == HBP_WAIT));
    end
  end

  always_comb begin
    if (style_sep) begin
      read_event = (cs_prev_reg && rd_prev_reg) && !(cs && rd);
    end else begin
      read_event = cs_prev_reg && rw && !cs;
    end
  end

  assign capture_event = (iack && !iack_prev_reg) || i_refresh_capture_command;

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_current_intr_capture <= `HBP_CIR_RESET;
    end else if (capture_event) begin
      if (i_arb_valid) begin
        o_current_intr_capture <= {i_arb_type, i_arb_channel};
      end else begin
        o_current_intr_capture <= `HBP_CIR_RESET;
      end
    end
  end

  // Context bits come from the capture, so a zero capture zeroes them too.
  always_comb begin
    if (i_intr_control[`HBP_ICR_USE_VREG]) begin
      vector_value = i_vector_reg;
    end else begin
      vector_value = `HBP_FIXED_VECTOR;
    end
    if (i_intr_control[`HBP_ICR_MOD_TYPE]) begin
      vector_value[7:5] = o_current_intr_capture[7:5];
    end
    if (i_intr_control[`HBP_ICR_MOD_CHAN]) begin
      vector_value[4:0] = o_current_intr_capture[4:0];
    end
  end

  assign is_global = (addr_reg == `HBP_ADDR_GBCR) || (addr_reg == `HBP_ADDR_GFIFO);

  always_comb begin
    if (iack) begin
      read_value = vector_value;
    end else if (addr_reg == `HBP_ADDR_GBCR) begin
      if (o_current_intr_capture[7:5] == `HBP_TYPE_TX) begin
        read_value = i_tx_fill[7:0];
      end else if (o_current_intr_capture[7:5] == `HBP_TYPE_RX) begin
        read_value = i_rx_fill[7:0];
      end else begin
        read_value = 8'h00;
      end
    end else if (addr_reg == `HBP_ADDR_GFIFO) begin
      read_value = i_rx_fifo_data;
    end else begin
      read_value = i_reg_rdata;
    end
  end

  // Read data is registered; the drive window follows the synchronised strobes.
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_data <= 8'h00;
      o_data_oe <= 1'b0;
    end else begin
      o_data <= read_value;
      if (style_sep) begin
        o_data_oe <= (cs && rd) || iack;
      end else begin
        o_data_oe <= (cs && rw) || iack;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_reg_addr <= 7'h00;
      o_reg_wdata <= 8'h00;
      o_reg_write <= 1'b0;
      o_reg_read <= 1'b0;
      o_rx_fifo_pop <= 1'b0;
      o_tx_fifo_push <= 1'b0;
    end else begin
      o_reg_addr <= addr_reg;
      o_reg_wdata <= wdata_hold_reg;
      o_reg_write <= write_event && !is_global;
      o_reg_read <= read_event && !is_global;
      o_rx_fifo_pop <= read_event && (addr_reg == `HBP_ADDR_GFIFO);
      o_tx_fifo_push <= write_event && (addr_reg == `HBP_ADDR_GFIFO);
    end
  end

  property p_ack_delay;
    @(posedge i_clock) disable iff (i_reset)
      $rose(o_transfer_ack_oe) |-> ($past(cs) || $past(iack)) &&
        ($past(cs, 2) || $past(iack, 2));
  endproperty
  a_ack_min_delay: assert property (p_ack_delay) else $error("ack too early");

  a_ack_sep_none: assert property (@(posedge i_clock) disable iff (i_reset)
    style_sep && $past(style_sep) && state_reg == HBP_IDLE |=> !o_transfer_ack_oe)
    else $error("ack in strobe style");

  a_ack_release: assert property (@(posedge i_clock) disable iff (i_reset)
    state_reg == HBP_DONE && !cs && !iack |=> !o_transfer_ack_oe)
    else $error("ack not released");

  sequence s_abandoned;
    state_reg == HBP_IDLE ##1 !o_transfer_ack_oe;
  endsequence
  a_abandon_ack: assert property (@(posedge i_clock) disable iff (i_reset)
    state_reg == HBP_WAIT && !cs && !iack |=> s_abandoned)
    else $error("abandoned ack appeared");

  a_capture_load: assert property (@(posedge i_clock) disable iff (i_reset)
    capture_event && i_arb_valid |=> o_current_intr_capture[7:5] == $past(i_arb_type) &&
      o_current_intr_capture[4:0] == $past(i_arb_channel))
    else $error("capture wrong");

  a_capture_zero: assert property (@(posedge i_clock) disable iff (i_reset)
    capture_event && !i_arb_valid |=> o_current_intr_capture == 8'h00)
    else $error("capture not zero");

  a_capture_hold: assert property (@(posedge i_clock) disable iff (i_reset)
    !capture_event |=> $stable(o_current_intr_capture))
    else $error("capture changed");

  a_read_drive: assert property (@(posedge i_clock) disable iff (i_reset)
    style_sep && !iack && !(cs && rd) |=> !o_data_oe)
    else $error("bus driven outside read");

  a_ack_max_wait: assert property (@(posedge i_clock) disable iff (i_reset)
    $rose(state_reg == HBP_WAIT) && cs |-> ##[1:7] (state_reg != HBP_WAIT))
    else $error("ack wait too long");
endmodule

/* hbp_defines.svh */
// Constants for the host bus port: delays, field positions and vector layout.
// Assumes it is included by the host bus port design file.
`ifndef HBP_DEFINES_SVH
`define HBP_DEFINES_SVH
`define HBP_CLK_PERIOD_NS 10
`define HBP_ACK_MIN_EDGES 2
`define HBP_ACK_MID_EDGES 4
`define HBP_ACK_MAX_EDGES 6
`define HBP_ACK_DLY_MSB 7
`define HBP_ACK_DLY_LSB 6
`define HBP_ICR_MOD_TYPE 0
`define HBP_ICR_MOD_CHAN 1
`define HBP_ICR_USE_VREG 2
`define HBP_FIXED_VECTOR 8'h0F
`define HBP_CIR_RESET 8'h00
`define HBP_ADDR_GBCR 7'h48
`define HBP_ADDR_GFIFO 7'h4B
`define HBP_TYPE_RX 3'h1
`define HBP_TYPE_TX 3'h2
`endif

/* hbp_pkg.sv */
// Types of the host bus port.
// Assumes hbp_defines.svh is on the include path.
package hbp_pkg;
  typedef enum logic [3:0] {
    HBP_IDLE = 4'h1,
    HBP_WAIT = 4'h2,
    HBP_ACK = 4'h4,
    HBP_DONE = 4'h8
  } hbp_state_type;
endpackage

/* hbp_host_model.sv */
// Host processor model: drives the port pins and runs one bus cycle per call.
// Assumes one clock; pins change only by non-blocking assignment at rising edges.
`timescale 1ns/1ps
module hbp_host_model (
  input wire logic i_clock,
  input wire logic [7:0] i_data,
  input wire logic i_data_oe,
  input wire logic i_ack_oe,
  output logic o_chip_select_low = 1'b1,
  output logic o_read_strobe_low = 1'b1,
  output logic o_write_strobe_low = 1'b1,
  output logic o_read_write_select = 1'b1,
  output logic o_intr_ack_low = 1'b1,
  output logic [6:0] o_addr = 7'h00,
  output logic [7:0] o_data
);
  logic [7:0] wdata_reg = 8'h00;
  logic drive_reg = 1'b0;
  logic [7:0] rdata;
  logic rdata_oe;
  int ack_cycles;
  // With no pull resistor a released bus shows the inverse of the last byte, not a held value.
  assign o_data = drive_reg ? wdata_reg : ~wdata_reg;
  // Kind 0 writes, 1 reads, 2 runs an interrupt acknowledge; hold bounds the wait.
  task automatic access(input logic ack_style, input int kind, input logic [6:0] addr,
                        input logic [7:0] data, input int hold);
    int n;
    n = 0;
    @(posedge i_clock);
    o_addr <= addr;
    wdata_reg <= data;
    drive_reg <= (kind == 0);
    o_read_write_select <= (kind != 0);
    if (kind == 2) o_intr_ack_low <= 1'b0;
    else o_chip_select_low <= 1'b0;
    if (!ack_style && kind == 0) o_write_strobe_low <= 1'b0;
    if (!ack_style && kind == 1) o_read_strobe_low <= 1'b0;
    do begin
      @(posedge i_clock);
      n++;
    end while (n < hold && !(ack_style && i_ack_oe === 1'b1));
    ack_cycles = (i_ack_oe === 1'b1) ? n : 0;
    rdata = i_data;
    rdata_oe = i_data_oe;
    // Strobes rise a cycle before select, so the strobe edge is the one that ends a write.
    o_write_strobe_low <= 1'b1;
    o_read_strobe_low <= 1'b1;
    @(posedge i_clock);
    o_chip_select_low <= 1'b1;
    o_intr_ack_low <= 1'b1;
    drive_reg <= 1'b0;
    repeat (6) @(posedge i_clock);
  endtask
endmodule

/* host_bus_port_intack_tb.sv */
// Self-checking testbench for the host bus port and its interrupt context capture.
// Assumes the host model in hbp_host_model.sv drives all bus pins.
`timescale 1ns/1ps
module host_bus_port_intack_tb;
  import hbp_pkg::*;
  logic i_clock = 1'b0;
  logic i_reset = 1'b1;
  logic style = 1'b1, refresh = 1'b0, arb_valid = 1'b0;
  logic [7:0] gcc = 8'h00, intr_control = 8'h00, vreg = 8'h5A, rdat = 8'hC3, fdat = 8'h77;
  logic [2:0] arb_type = 3'h0;
  logic [4:0] arb_chan = 5'h00;
  logic [8:0] rx_fill = 9'h011, tx_fill = 9'h022;
  logic cs_n, rd_n, wr_n, rw, iack_n, d_oe, ack_low, ack_oe;
  logic [6:0] addr, reg_addr, wr_addr;
  logic [7:0] host_d, dut_d, cap, reg_wd, wr_data;
  logic reg_wr, reg_rd, pop, push;
  int n_mismatch = 0, check_count = 0, n_wr = 0, n_pop = 0, n_rd = 0, n_push = 0, lat[4], k;
  logic [7:0] exp_vec[3] = '{8'h0F, 8'h5A, 8'h23};
  logic [7:0] icr_set[3] = '{8'h00, 8'h04, 8'h03};
  hbp_host_port u_dut (.i_clock(i_clock), .i_reset(i_reset), .i_bus_style_select(style),
    .i_chip_select_low(cs_n), .i_read_strobe_low(rd_n), .i_write_strobe_low(wr_n),
    .i_read_write_select(rw), .i_intr_ack_low(iack_n), .i_addr(addr), .i_data(host_d),
    .o_data(dut_d), .o_data_oe(d_oe), .o_transfer_ack_low(ack_low),
    .o_transfer_ack_oe(ack_oe), .i_global_chip_config(gcc), .i_intr_control(intr_control),
    .i_vector_reg(vreg), .i_refresh_capture_command(refresh), .i_arb_valid(arb_valid),
    .i_arb_type(arb_type), .i_arb_channel(arb_chan), .i_reg_rdata(rdat),
    .i_rx_fill(rx_fill), .i_tx_fill(tx_fill), .i_rx_fifo_data(fdat),
    .o_current_intr_capture(cap), .o_reg_addr(reg_addr), .o_reg_wdata(reg_wd),
    .o_reg_write(reg_wr), .o_reg_read(reg_rd), .o_rx_fifo_pop(pop), .o_tx_fifo_push(push));
  hbp_host_model u_host (.i_clock(i_clock), .i_data(dut_d), .i_data_oe(d_oe),
    .i_ack_oe(ack_oe), .o_chip_select_low(cs_n), .o_read_strobe_low(rd_n),
    .o_write_strobe_low(wr_n), .o_read_write_select(rw), .o_intr_ack_low(iack_n),
    .o_addr(addr), .o_data(host_d));
  initial begin
    forever #5 i_clock = ~i_clock;
  end
  always @(posedge i_clock) begin
    if (reg_wr === 1'b1) begin
      n_wr++;
      wr_addr = reg_addr;
      wr_data = reg_wd;
    end
    if (pop === 1'b1) n_pop++;
    if (reg_rd === 1'b1) n_rd++;
    if (push === 1'b1) n_push++;
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic acc(input logic ack, input int kind, input logic [6:0] a,
                     input logic [7:0] d, input int hold, input logic want_ack);
    u_host.access(ack, kind, a, d, hold);
    if (want_ack && u_host.ack_cycles == 0) begin
      n_mismatch++;
      $display("mismatch transfer_ack expected 1 seen 0");
      wrap_up();
    end
  endtask
  task automatic pulse_refresh();
    @(posedge i_clock) refresh <= 1'b1;
    @(posedge i_clock) refresh <= 1'b0;
    repeat (4) @(posedge i_clock);
  endtask
  initial begin
    repeat (20000) @(posedge i_clock);
    n_mismatch++;
    wrap_up();
  end
  initial begin
    repeat (5) @(posedge i_clock);
    i_reset <= 1'b0;
    acc(1'b0, 0, 7'h15, 8'h3C, 8, 1'b0);
    check("wr_count", 1, n_wr);
    check("wr_addr", 7'h15, wr_addr);
    check("wr_data", 8'h3C, wr_data);
    check("ack_sep", 0, u_host.ack_cycles);
    acc(1'b0, 1, 7'h7F, 8'h00, 8, 1'b0);
    check("rd_oe", 1, u_host.rdata_oe);
    check("rd_data", 8'hC3, u_host.rdata);
    check("rd_release", 0, d_oe);
    check("rd_count", 1, n_rd);
    $display("test separate strobes done");
    @(posedge i_clock) style <= 1'b0;
    for (k = 0; k < 4; k++) begin
      @(posedge i_clock) gcc <= {k[1:0], 6'h00};
      acc(1'b1, 0, 7'h20 + 7'(k), 8'h90 + 8'(k), 20, 1'b1);
      lat[k] = u_host.ack_cycles;
      check("ack_wr_data", 8'h90 + 8'(k), wr_data);
      check("ack_wr_count", 2 + k, n_wr);
      check("ack_release", 0, ack_oe);
    end
    check("ack_level", 0, ack_low);
    check("lat_min", 1, lat[0] >= 2);
    check("lat_mid", 2, lat[1] - lat[0]);
    check("lat_max", 4, lat[2] - lat[0]);
    check("lat_code3", lat[2], lat[3]);
    acc(1'b1, 1, 7'h33, 8'h00, 20, 1'b1);
    check("ack_rd_data", 8'hC3, u_host.rdata);
    check("ack_rd_oe", 1, u_host.rdata_oe);
    check("ack_rd_count", 2, n_rd);
    acc(1'b1, 0, 7'h21, 8'hAB, 1, 1'b0);
    check("abort_ack", 0, u_host.ack_cycles);
    check("abort_wr", 8'hAB, wr_data);
    $display("test acknowledge style done");
    @(posedge i_clock) arb_valid <= 1'b1;
    arb_type <= 3'h1;
    arb_chan <= 5'h03;
    for (k = 0; k < 3; k++) begin
      @(posedge i_clock) intr_control <= icr_set[k];
      acc(1'b1, 2, 7'h00, 8'h00, 20, 1'b1);
      check("vector", exp_vec[k], u_host.rdata);
      check("capture", 8'h23, cap);
    end
    @(posedge i_clock) arb_type <= 3'h2;
    arb_chan <= 5'h05;
    repeat (4) @(posedge i_clock);
    check("capture_hold", 8'h23, cap);
    acc(1'b1, 1, 7'h48, 8'h00, 20, 1'b1);
    check("gbcr_rx", 8'h11, u_host.rdata);
    acc(1'b1, 1, 7'h4B, 8'h00, 20, 1'b1);
    check("fifo_rd", 8'h77, u_host.rdata);
    check("fifo_pop", 1, n_pop);
    acc(1'b1, 0, 7'h4B, 8'hE1, 20, 1'b1);
    check("fifo_push", 1, n_push);
    check("fifo_no_reg_wr", 6, n_wr);
    pulse_refresh();
    check("capture_refresh", 8'h45, cap);
    acc(1'b1, 1, 7'h48, 8'h00, 20, 1'b1);
    check("gbcr_tx", 8'h22, u_host.rdata);
    @(posedge i_clock) arb_valid <= 1'b0;
    pulse_refresh();
    check("capture_none", 8'h00, cap);
    acc(1'b1, 2, 7'h00, 8'h00, 20, 1'b1);
    check("vector_none", 8'h00, u_host.rdata);
    $display("test interrupt context done");
    wrap_up();
  end
endmodule
